// ---- rtl/adc_lvds_output_serializer.sv ----
// lvds output stage: latency pipeline, word sizing and serial lanes with frame and bit clocks
//
// Notes on behaviour
// - results leave after 11 samples, 8 when shortened
// - frame clock changes exactly like a data lane
// - 12-bit words drop two lowest result bits
// - 16-bit words append two zero low bits
// - size fields select 12/14/16 bits, 6x/7x/8x clock
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ns
`include "serializer_defines.svh"
module adc_lvds_output_serializer
   import serializer_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic sampleClock,
   input wire sampleSet_t convResult,
   output logic frameClock,
   output logic bitClock,
   output logic [`CHANNELS-1:0] serialData
);
   logic [15:0] latencyCfg;
   logic [15:0] sizeCfg;
   logic [15:0] auxCfg;
   logic overrun;
   logic wrPend;
   logic [5:0] wrIdx;
   logic sampleMeta;
   logic sampleSync;
   logic sampleLast;
   logic tick;
   wordMode_e curMode;
   sampleSet_t pipe [`LAT_NORMAL];
   logic [`LAT_NORMAL-1:0] pipeValid;
   logic [3:0] tapIdx;
   logic pushValid;
   logic pushReady;
   convWord_s pushWord;
   logic popValid;
   convWord_s popWord;
   serState_e state;
   logic loadNow;
   logic phase;
   logic [4:0] bitIdx;
   logic [4:0] nBits;
   wordMode_e frameMode;
   logic frameEnd;
   logic [`CHANNELS-1:0][15:0] shiftReg;
   logic [3:0] tickCnt;

   // ======================================
   // bus slave: zero wait states, read data registered in address phase
   function automatic logic [31:0] readWord(input logic [5:0] idx);
      logic [31:0] v;
      v = '0;
      case (idx)
         `IDX_LATENCY: v[15:0] = latencyCfg;
         `IDX_WORDSIZE: v[15:0] = sizeCfg;
         `IDX_AUX: v[15:0] = auxCfg;
         `IDX_STATUS: begin
            v[`OVERRUN_BIT] = overrun;
            v[`BUSY_BIT] = (state == SER_SHIFT);
         end
         default: v = '0;
      endcase
      // forward a write still in its data phase, else a back to back read sees stale data
      if (wrPend && wrIdx == idx && idx != `IDX_STATUS) begin
         v = {16'h0000, hwdata[15:0]};
      end
      return v;
   endfunction

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPend <= 1'b0;
         wrIdx <= '0;
         hrdata <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (hready) begin
         wrPend <= hsel && htrans[1] && hwrite;
         wrIdx <= haddr[7:2];
         if (hsel && htrans[1] && !hwrite) begin
            hrdata <= readWord(haddr[7:2]);
         end
      end
   end

   // configuration registers, unmapped writes are dropped
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         latencyCfg <= `REG_RESET;
         sizeCfg <= `REG_RESET;
         auxCfg <= `REG_RESET;
      end else if (wrPend) begin
         case (wrIdx)
            `IDX_LATENCY: latencyCfg <= hwdata[15:0];
            `IDX_WORDSIZE: sizeCfg <= hwdata[15:0];
            `IDX_AUX: auxCfg <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // overrun is sticky, write one clears, a new overrun wins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         overrun <= 1'b0;
      end else if (pushValid && !pushReady) begin
         overrun <= 1'b1;
      end else if (wrPend && wrIdx == `IDX_STATUS && hwdata[`OVERRUN_BIT]) begin
         overrun <= 1'b0;
      end
   end

   // ======================================
   // word size decode, undocumented combinations fall back to 14 bits
   always_comb begin
      curMode = WM14;
      if (sizeCfg[`SIZE_HI:`SIZE_LO] == `SIZE_12 && auxCfg[`AUX_HI:`AUX_LO] == `AUX_12) begin
         curMode = WM12;
      end else if (sizeCfg[`SIZE_HI:`SIZE_LO] == `SIZE_16 && auxCfg[`AUX_HI:`AUX_LO] == `AUX_STD) begin
         curMode = WM16;
      end
   end

   // ======================================
   // sample clock synchroniser, rising edge gives the sample tick
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sampleMeta <= 1'b0;
         sampleSync <= 1'b0;
         sampleLast <= 1'b0;
      end else begin
         sampleMeta <= sampleClock;
         sampleSync <= sampleMeta;
         sampleLast <= sampleSync;
      end
   end
   assign tick = sampleSync && !sampleLast;

   // ======================================
   // latency line advances once per sample clock
   generate
      for (genvar s = 0; s < `LAT_NORMAL; s++) begin : g_stage
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               pipe[s] <= '0;
               pipeValid[s] <= 1'b0;
            end else if (tick) begin
               pipe[s] <= (s == 0) ? convResult : pipe[(s == 0) ? 0 : s - 1];
               pipeValid[s] <= (s == 0) ? 1'b1 : pipeValid[(s == 0) ? 0 : s - 1];
            end
         end
      end
   endgenerate

   // tap picks stage so a result leaves on the 11th or 8th tick after capture
   assign tapIdx = latencyCfg[`LOWLAT_BIT] ? 4'(`LAT_SHORT - 1) : 4'(`LAT_NORMAL - 1);
   assign pushValid = tick && pipeValid[tapIdx];
   assign pushWord = '{mode: curMode, sample: pipe[tapIdx]};

   // the receiver cannot stall, so a full buffer shows up as overrun
   word_buffer #(
      .WIDTH($bits(convWord_s)),
      .DEPTH(2)
   ) u_buffer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .inValid(pushValid),
      .inReady(pushReady),
      .inData(pushWord),
      .outValid(popValid),
      .outReady(state == SER_IDLE),
      .outData(popWord)
   );

   // ======================================
   // frame sequencer: two core cycles per bit, bit clock toggles mid bit
   assign loadNow = popValid && (state == SER_IDLE);
   assign frameEnd = (state == SER_SHIFT) && phase && (bitIdx == nBits - 5'd1);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= SER_IDLE;
         phase <= 1'b0;
         bitIdx <= '0;
         nBits <= `BITS_14;
         frameMode <= WM14;
         frameClock <= 1'b0;
         bitClock <= 1'b0;
      end else begin
         case (state)
            SER_IDLE: begin
               if (loadNow) begin
                  state <= SER_SHIFT;
                  phase <= 1'b0;
                  bitIdx <= '0;
                  frameMode <= popWord.mode;
                  case (popWord.mode)
                     WM12: nBits <= `BITS_12;
                     WM16: nBits <= `BITS_16;
                     default: nBits <= `BITS_14;
                  endcase
               end
            end
            SER_SHIFT: begin
               if (!phase) begin
                  // frame clock high for first half of the word, same timing as data
                  frameClock <= (bitIdx < (nBits >> 1));
                  phase <= 1'b1;
               end else begin
                  bitClock <= ~bitClock;
                  phase <= 1'b0;
                  if (frameEnd) begin
                     state <= SER_IDLE;
                  end else begin
                     bitIdx <= bitIdx + 5'd1;
                  end
               end
            end
            default: state <= SER_IDLE;
         endcase
      end
   end

   // ======================================
   // one lane per channel, msb first; short words just stop early
   generate
      for (genvar c = 0; c < `CHANNELS; c++) begin : g_lane
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               shiftReg[c] <= '0;
               serialData[c] <= 1'b0;
            end else if (loadNow) begin
               // top 12 bits keep result[13:2], two zeros pad the 16th bits
               shiftReg[c] <= {popWord.sample[c], 2'b00};
            end else if (state == SER_SHIFT && !phase) begin
               serialData[c] <= shiftReg[c][15];
               shiftReg[c] <= {shiftReg[c][14:0], 1'b0};
            end
         end
      end
   endgenerate

   // ======================================
   // checks; tick counter is helper state for the latency check
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tickCnt <= '0;
      end else if (tick && tickCnt != 4'hF) begin
         tickCnt <= tickCnt + 4'd1;
      end
   end

   lat_first_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (tick && tickCnt == tapIdx + 4'd1) |-> pushValid && pushWord.sample == pipe[tapIdx])
      else $error("latency tap not ready on time");
   lat_early_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      pushValid |-> tickCnt > tapIdx)
      else $error("result released too early");
   frame_lane_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      ($changed(frameClock) || $changed(serialData)) |-> !$changed(bitClock))
      else $error("frame or data moved on a bit clock edge");
   trunc_twelve_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (loadNow && popWord.mode == WM12) |-> ##24 frameEnd ##1 (state == SER_IDLE || !$past(frameEnd, 2)))
      else $error("12-bit frame length wrong");
   pad_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (frameEnd && frameMode == WM16) |-> serialData == '0 && $past(serialData, 2) == '0)
      else $error("16-bit padding not zero");
   size_frame_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (loadNow && popWord.mode == WM14) |-> ##28 frameEnd)
      else $error("14-bit frame length wrong");
   word_span_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (loadNow && popWord.mode == WM16) |-> ##2 serialData[0] == $past(popWord.sample[0][13], 2) ##30 frameEnd)
      else $error("16-bit frame wrong");

   cover_twelve: cover property (@(posedge core_clk) disable iff (!rst_n) loadNow && popWord.mode == WM12);
   cover_sixteen: cover property (@(posedge core_clk) disable iff (!rst_n) loadNow && popWord.mode == WM16);
   cover_short: cover property (@(posedge core_clk) disable iff (!rst_n) pushValid && latencyCfg[`LOWLAT_BIT]);
   cover_overrun: cover property (@(posedge core_clk) disable iff (!rst_n) pushValid && !pushReady);
endmodule

// ---- rtl/serializer_defines.svh ----
// constants for the lvds output serializer: map, fields, resets, latencies
`ifndef SERIALIZER_DEFINES_SVH
`define SERIALIZER_DEFINES_SVH
// ======================================
// register indices, byte address is four times the index
`define IDX_LATENCY 6'h02
`define IDX_WORDSIZE 6'h03
`define IDX_AUX 6'h04
`define IDX_STATUS 6'h05
`define REG_RESET 16'h0000
// ======================================
// field positions
`define LOWLAT_BIT 12
`define SIZE_HI 14
`define SIZE_LO 13
`define AUX_HI 2
`define AUX_LO 0
`define OVERRUN_BIT 0
`define BUSY_BIT 1
// ======================================
// word size codes
`define SIZE_12 2'h3
`define SIZE_14 2'h0
`define SIZE_16 2'h1
`define AUX_12 3'h2
`define AUX_STD 3'h0
`define BITS_12 5'h0C
`define BITS_14 5'h0E
`define BITS_16 5'h10
// ======================================
// latency in sample clock cycles, channel count
`define LAT_NORMAL 11
`define LAT_SHORT 8
`define CHANNELS 8
`define RESULT_BITS 14
`endif

// ---- rtl/serializer_pkg.sv ----
// types shared by the lvds output serializer
package serializer_pkg;
`include "serializer_defines.svh"
   typedef enum logic [1:0] {
      WM14 = 2'b00,
      WM16 = 2'b01,
      WM12 = 2'b10
   } wordMode_e;
   typedef enum logic {
      SER_IDLE = 1'b0,
      SER_SHIFT = 1'b1
   } serState_e;
   typedef logic [`CHANNELS-1:0][`RESULT_BITS-1:0] sampleSet_t;
   // one frame worth of results with the word size fixed at entry
   typedef struct packed {
      wordMode_e mode;
      sampleSet_t sample;
   } convWord_s;
endpackage

// ---- rtl/word_buffer.sv ----
// small valid/ready buffer between latency pipeline and serializer
`timescale 1ns/1ns
module word_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0] wrPtr;
   logic [PW-1:0] rdPtr;
   logic [CW-1:0] count;
   logic doPush;
   logic doPop;

   // ======================================
   // handshakes
   assign inReady = (count != CW'(DEPTH));
   assign outValid = (count != '0);
   assign outData = store[rdPtr];
   assign doPush = inValid && inReady;
   assign doPop = outValid && outReady;

   // storage written by index
   always_ff @(posedge core_clk) begin
      if (doPush) begin
         store[wrPtr] <= inData;
      end
   end

   // pointers wrap at depth
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doPush) begin
            wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
         end
         if (doPop) begin
            rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
         end
         if (doPush && !doPop) begin
            count <= count + 1'b1;
         end else if (doPop && !doPush) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// ---- tb/lvds_capture_model.sv ----
// receiving fpga model: deserializes every lane on both bit clock edges
`timescale 1ns/1ns
module lvds_capture_model (
   input wire logic bitClock,
   input wire logic frameClock,
   input wire logic [7:0] serialData,
   input wire logic [4:0] wordBits,
   output logic [7:0][15:0] word,
   output int words,
   output int frameHigh
);
   logic [7:0][15:0] shiftReg = '0;
   logic lastFrame = 1'b0;
   int bitCnt = 0;
   int highCnt = 0;
   int wordCnt = 0;
   // one driver for the word count, the capture process below
   assign words = wordCnt;
   // frame clock is captured exactly like a data lane, its rise marks bit 0
   always @(bitClock) begin
      if ($time > 0) begin
         if (frameClock && !lastFrame) begin
            bitCnt = 0;
            highCnt = 0;
            // stale bits of the previous frame must not show above a short word
            shiftReg = '0;
         end
         for (int c = 0; c < 8; c++) begin
            shiftReg[c] = {shiftReg[c][14:0], serialData[c]};
         end
         bitCnt++;
         highCnt += int'(frameClock);
         if (bitCnt == int'(wordBits)) begin
            word = shiftReg;
            wordCnt++;
            frameHigh = highCnt;
         end
         lastFrame = frameClock;
      end
   end
endmodule

// ---- tb/test_adc_lvds_output_serializer.sv ----
// self-checking bench for the lvds output serializer
`timescale 1ns/1ns
`include "serializer_defines.svh"
module test_adc_lvds_output_serializer;
   import serializer_pkg::*;
   typedef struct {logic [1:0] size; logic [2:0] aux; logic low; logic [4:0] bits; int lat;} row_s;
   logic core_clk, rst_n, hsel, hwrite, sampleClock, hreadyout, hresp, frameClock, bitClock;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [7:0] serialData;
   logic [4:0] wordBits;
   logic [7:0][15:0] word;
   sampleSet_t convResult;
   int words, frameHigh, riseCnt, sPhase, failures, tests_run;
   // 500 ns sample period: a 125 ns one cannot hold a whole frame of 2N+1 core cycles
   int halfCyc = 25;
   row_s rows[6] = '{'{`SIZE_12, `AUX_12, 1'b0, `BITS_12, `LAT_NORMAL},
      '{`SIZE_14, `AUX_STD, 1'b0, `BITS_14, `LAT_NORMAL}, '{`SIZE_16, `AUX_STD, 1'b0, `BITS_16, `LAT_NORMAL},
      '{`SIZE_16, `AUX_STD, 1'b1, `BITS_16, `LAT_SHORT}, '{`SIZE_12, `AUX_12, 1'b1, `BITS_12, `LAT_SHORT},
      '{`SIZE_12, `AUX_STD, 1'b0, `BITS_14, `LAT_NORMAL}};
   adc_lvds_output_serializer dut_u (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sampleClock(sampleClock), .convResult(convResult),
      .frameClock(frameClock), .bitClock(bitClock), .serialData(serialData));
   lvds_capture_model model_u (.bitClock(bitClock), .frameClock(frameClock), .serialData(serialData),
      .wordBits(wordBits), .word(word), .words(words), .frameHigh(frameHigh));
   // ======================================
   // clocks and sample stream
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // each sample carries its lane number and the count of sample clock rises
   always @(posedge core_clk) begin
      if (sPhase >= halfCyc - 1) begin
         sPhase <= 0;
         sampleClock <= ~sampleClock;
         if (sampleClock) begin
            for (int c = 0; c < 8; c++) begin
               convResult[c] <= {3'(c), 9'(riseCnt), 2'h3};
            end
         end else begin
            riseCnt <= riseCnt + 1;
         end
      end else begin
         sPhase <= sPhase + 1;
      end
   end
   // ======================================
   // bus, compare and wait tasks
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      rd = hrdata;
      chkReg({31'h0, hresp}, 32'h0);
   endtask
   task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t register got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkLink(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t link got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic waitWord();
      int w;
      w = words;
      for (int n = 0; n < 2000 && words == w; n++) @(posedge core_clk);
      if (words == w) chkLink(16'h0, 16'h1);
   endtask
   // frame check: sample index is read back from lane 0, latency and lane values follow from it, frame high count from the row
   task automatic checkFrame(input row_s r);
      logic [13:0] v;
      logic [13:0] e;
      v = (r.bits == `BITS_12) ? {word[0][11:0], 2'h3} : (r.bits == `BITS_16) ? word[0][15:2] : word[0][13:0];
      chkLink(16'(riseCnt - int'(v[10:2])) & 16'h01FF, 16'(r.lat + 1));
      chkLink(16'(frameHigh), 16'(r.bits / 2));
      for (int c = 0; c < 8; c++) begin
         e = {3'(c), v[10:2], 2'h3};
         chkLink(word[c], (r.bits == `BITS_12) ? 16'(e[13:2]) : (r.bits == `BITS_16) ? {e, 2'h0} : 16'(e));
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ======================================
   // main sequence
   initial begin
      {rst_n, hsel, hwrite, sampleClock, haddr, hwdata, htrans, convResult} = '0;
      {riseCnt, sPhase, failures, tests_run} = '0;
      wordBits = `BITS_14;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int a = 2; a < 6; a++) begin
         xfer(1'b0, 32'(a * 4), 32'h0);
         chkReg(rd, 32'(`REG_RESET));
      end
      xfer(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
      xfer(1'b0, 32'h0000_0040, 32'h0);
      chkReg(rd, 32'h0);
      xfer(1'b1, 32'(`IDX_AUX * 4), 32'hFFFF_FFFF);
      xfer(1'b0, 32'(`IDX_AUX * 4), 32'h0);
      chkReg(rd, 32'h0000_FFFF);
      $display("register test done");
      foreach (rows[i]) begin
         xfer(1'b1, 32'(`IDX_WORDSIZE * 4), 32'(rows[i].size) << `SIZE_LO);
         xfer(1'b1, 32'(`IDX_AUX * 4), 32'(rows[i].aux));
         xfer(1'b1, 32'(`IDX_LATENCY * 4), 32'(rows[i].low) << `LOWLAT_BIT);
         wordBits = rows[i].bits;
         repeat (14) waitWord();
         repeat (3) begin
            waitWord();
            checkFrame(rows[i]);
         end
         xfer(1'b0, 32'(`IDX_STATUS * 4), 32'h0);
         chkReg(rd & 32'h1, 32'h0);
         $display("row %0d done", i);
      end
      // 200 ns sample period is shorter than a 14-bit frame: the buffer must refuse and flag it
      halfCyc = 10;
      repeat (1800) @(posedge core_clk);
      xfer(1'b0, 32'(`IDX_STATUS * 4), 32'h0);
      chkReg(rd & 32'h1, 32'h1);
      halfCyc = 25;
      repeat (2000) @(posedge core_clk);
      xfer(1'b1, 32'(`IDX_STATUS * 4), 32'h1);
      xfer(1'b0, 32'(`IDX_STATUS * 4), 32'h0);
      chkReg(rd & 32'h1, 32'h0);
      $display("overrun test done");
      // mid-run reset: link outputs, bus outputs and registers return to idle values
      @(posedge core_clk);
      rst_n <= 1'b0;
      @(posedge core_clk);
      chkLink({frameClock, bitClock, 6'h00, serialData}, 16'h0000);
      chkReg(hrdata, 32'h0);
      chkReg({30'h0, hresp, hreadyout}, 32'h1);
      @(posedge core_clk);
      rst_n <= 1'b1;
      xfer(1'b0, 32'(`IDX_WORDSIZE * 4), 32'h0);
      chkReg(rd, 32'(`REG_RESET));
      xfer(1'b0, 32'(`IDX_AUX * 4), 32'h0);
      chkReg(rd, 32'(`REG_RESET));
      $display("reset test done");
      report_and_stop();
   end
   // watchdog, about four times the expected run
   initial begin
      #400000;
      failures++;
      report_and_stop();
   end
endmodule
